// *** design/timer_subsys_defs.vh ***
// constants for the dual timer, pwm and watchdog subsystem
`ifndef TIMER_SUBSYS_DEFS_VH
`define TIMER_SUBSYS_DEFS_VH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define A_PRESCALER_CTRL 8'h00
`define A_T1_CTRL 8'h04
`define A_T2_CTRL 8'h08
`define A_PIN0_CTRL 8'h0c
`define A_PIN1_CTRL 8'h10
`define A_EXT_IRQ_CTRL 8'h14
`define A_PRESC_RELOAD 8'h18
`define A_T1_RELOAD 8'h1c
`define A_T2_LOW_RELOAD 8'h20
`define A_T2_HIGH_RELOAD 8'h24
`define A_T1_COUNT 8'h28
`define A_T2_COUNT 8'h2c
`define A_PERIOD_CAPTURE 8'h30
`define A_IRQ_STATUS 8'h34
`define A_IRQ_ENABLE 8'h38
`define A_WDT_CTRL 8'h3c
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RST_CTRL4 4'h0
`define RST_RELOAD8 8'hff
// -----------------------------------------------------------------
// status / enable bit positions
// -----------------------------------------------------------------
`define IRQ_EXT 0
`define IRQ_T1 1
`define IRQ_T2 2
`define IRQ_PERIOD 3
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define SYS_CLK_MHZ 100
`define MC_DIV_LAST 2'd2
`define WDT_LIMIT 16'hfffe
`endif

// *** design/timer_subsys.v ***
// dual timer, pwm, event counter and watchdog behind an apb slave
//
// Operation
// - timer 1 underflows toggle counter pin 0 into a square wave and set the timer 1 request at the same events.
// - a timer 1 interval is clock period times 3 times (prescaler reload+1) times (timer 1 reload+1).
// - counter pin 0 goes to high impedance when reselected as a counter input.
// - timer 2 counts selected edges of counter pin 0 when that pin is its count source.
// - an external pin edge starts timer 1 through the start synchroniser.
// - the timer 1 reload register holds any value such as 0x52 and the trigger edge is selectable.
// - timer 2 on the system clock makes a pwm wave on counter pin 1.
// - in period mode timer 2 counts ticks of its count source (system clocks with source 11) between two rising external pin edges.
// - at every timer 2 underflow in pwm mode it reloads alternately from the low and high reload registers.
// - with bit 2 of the pin 1 control set, each timer 1 underflow toggles whether pwm reaches counter pin 1.
// - the watchdog asks for reset when not restarted within 65535 machine cycles.
// - timer 1 source 00 pwm, 01 prescaler, 10 counter pin 1, 11 ring oscillator.
// - timer 2 source 00 timer 1 underflow, 01 prescaler, 10 counter pin 0, 11 system clock.
// - the start synchroniser acts only with external pin control enabled, auto-stop also needs the synchroniser.
//
// Chosen here: register access over APB and the register offsets.
`include "timer_subsys_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module timer_subsys (
    input wire CLK_SYS,
    input wire RST,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire COUNTER_PIN_ZERO_IN,
    output reg COUNTER_PIN_ZERO_OUT,
    output reg COUNTER_PIN_ZERO_OE_N,
    input wire COUNTER_PIN_ONE_IN,
    output reg COUNTER_PIN_ONE_OUT,
    output reg COUNTER_PIN_ONE_OE_N,
    input wire INT_IN,
    input wire RING_CLK_IN,
    output reg IRQ,
    output reg WDT_RESET
);

// -----------------------------------------------------------------
// control registers
// -----------------------------------------------------------------
reg prescaler_ctrl_r;
reg [3:0] t1_ctrl_r;
reg [3:0] t2_ctrl_r;
reg [3:0] pin0_counter_ctrl_r;
reg [3:0] pin1_counter_ctrl_r;
reg [3:0] ext_pin_irq_ctrl_r;
reg [7:0] prescaler_reload_value_r;
reg [7:0] t1_reload_value_r;
reg [7:0] t2_low_period_reload_r;
reg [7:0] t2_high_period_reload_r;
reg [3:0] irq_status_r;
reg [3:0] irq_enable_ctrl_r;
reg wdt_en_r;

// -----------------------------------------------------------------
// pin synchronisers: bit0 pin0, bit1 pin1, bit2 ext int, bit3 ring
// -----------------------------------------------------------------
reg [3:0] sync1_r;
reg [3:0] sync2_r;
reg [3:0] hist_r;

// two flops per pin, then one history flop for edge detection
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        sync1_r <= 4'h0;
        sync2_r <= 4'h0;
        hist_r <= 4'h0;
    end else if (CE) begin
        sync1_r <= {RING_CLK_IN, INT_IN, COUNTER_PIN_ONE_IN,
            COUNTER_PIN_ZERO_IN};
        sync2_r <= sync1_r;
        hist_r <= sync2_r;
    end
end

wire [3:0] rise = sync2_r & ~hist_r;
wire [3:0] fall = ~sync2_r & hist_r;
// counter pin edges, edge chosen by bit 0 of each pin control
wire pin0_edge = pin0_counter_ctrl_r[0] ? rise[0] : fall[0];
wire pin1_edge = pin1_counter_ctrl_r[0] ? rise[1] : fall[1];
// external pin: enable bit3, polarity bit2, both edges bit1
wire ext_edge = ext_pin_irq_ctrl_r[3] & (ext_pin_irq_ctrl_r[1] ?
    (rise[2] | fall[2]) :
    (ext_pin_irq_ctrl_r[2] ? rise[2] : fall[2]));

// -----------------------------------------------------------------
// apb decode
// -----------------------------------------------------------------
wire acc = PSEL & PENABLE & PREADY;
wire wr = acc & PWRITE;
wire [3:0] wd4 = PWDATA[3:0];
wire [7:0] wd8 = PWDATA[7:0];

// -----------------------------------------------------------------
// machine cycle divider and prescaler
// -----------------------------------------------------------------
reg [1:0] mc_cnt_r;
reg [7:0] presc_cnt_r;
reg presc_out_r;
wire mc_tick = (mc_cnt_r == `MC_DIV_LAST);

// one machine cycle is three system clocks
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        mc_cnt_r <= 2'd0;
    end else if (CE) begin
        mc_cnt_r <= mc_tick ? 2'd0 : mc_cnt_r + 2'd1;
    end
end

// prescaler counts machine cycles, pulses on underflow
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        presc_cnt_r <= `RST_RELOAD8;
        presc_out_r <= 1'b0;
    end else if (CE) begin
        presc_out_r <= 1'b0;
        if (!prescaler_ctrl_r) begin
            presc_cnt_r <= prescaler_reload_value_r;
        end else if (mc_tick) begin
            if (presc_cnt_r == 8'h00) begin
                presc_cnt_r <= prescaler_reload_value_r;
                presc_out_r <= 1'b1;
            end else begin
                presc_cnt_r <= presc_cnt_r - 8'h01;
            end
        end
    end
end

// -----------------------------------------------------------------
// timer 1
// -----------------------------------------------------------------
reg [7:0] t1_cnt_r;
reg t1_started_r;
reg t2_pwm_signal_r;
reg t2_pwm_hist_r;
reg t1_src;
wire start_sync_en = ext_pin_irq_ctrl_r[0] & pin0_counter_ctrl_r[1];
wire auto_stop_en = start_sync_en & pin0_counter_ctrl_r[2];
wire t1_run = t1_ctrl_r[2] & (~start_sync_en | t1_started_r);
wire t1_tick = t1_run & t1_src;
wire t1_underflow_sig = t1_tick & (t1_cnt_r == 8'h00);

// timer 1 count source select
always @* begin
    case (t1_ctrl_r[1:0])
        2'b00: t1_src = t2_pwm_signal_r & ~t2_pwm_hist_r;
        2'b01: t1_src = presc_out_r;
        2'b10: t1_src = pin1_edge;
        2'b11: t1_src = rise[3];
        default: t1_src = 1'b0;
    endcase
end

// down counter with reload, loaded on write while stopped
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        t1_cnt_r <= `RST_RELOAD8;
    end else if (CE) begin
        if (wr && PADDR == `A_T1_RELOAD && !t1_ctrl_r[2]) begin
            t1_cnt_r <= wd8;
        end else if (t1_tick) begin
            t1_cnt_r <= (t1_cnt_r == 8'h00) ? t1_reload_value_r :
                t1_cnt_r - 8'h01;
        end
    end
end

// start synchroniser and auto-stop
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        t1_started_r <= 1'b0;
    end else if (CE) begin
        if (!start_sync_en) begin
            t1_started_r <= 1'b0;
        end else if (ext_edge) begin
            t1_started_r <= 1'b1;
        end else if (auto_stop_en && t1_underflow_sig) begin
            t1_started_r <= 1'b0;
        end
    end
end

// -----------------------------------------------------------------
// timer 2
// -----------------------------------------------------------------
reg [7:0] t2_cnt_r;
reg [7:0] period_cap_r;
reg t2_src;
wire period_mode = pin1_counter_ctrl_r[1];
wire t2_tick = t2_ctrl_r[2] & t2_src;
wire t2_udf = t2_tick & ~period_mode & (t2_cnt_r == 8'h00);
wire period_edge = period_mode & t2_ctrl_r[2] & rise[2];

// timer 2 count source select
always @* begin
    case (t2_ctrl_r[1:0])
        2'b00: t2_src = t1_underflow_sig;
        2'b01: t2_src = presc_out_r;
        2'b10: t2_src = pin0_edge;
        2'b11: t2_src = 1'b1;
        default: t2_src = 1'b0;
    endcase
end

// down counter, pwm reload or period up-count
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        t2_cnt_r <= `RST_RELOAD8;
        t2_pwm_signal_r <= 1'b0;
        period_cap_r <= 8'h00;
    end else if (CE) begin
        if (period_edge) begin
            period_cap_r <= t2_cnt_r;
            t2_cnt_r <= 8'h01; // edge cycle counts as the first
        end else if (wr && PADDR == `A_T2_LOW_RELOAD && !t2_ctrl_r[2]) begin
            t2_cnt_r <= wd8;
        end else if (t2_tick && period_mode) begin
            t2_cnt_r <= t2_cnt_r + 8'h01;
        end else if (t2_udf && t2_ctrl_r[3]) begin
            t2_pwm_signal_r <= ~t2_pwm_signal_r;
            t2_cnt_r <= t2_pwm_signal_r ? t2_low_period_reload_r :
                t2_high_period_reload_r;
        end else if (t2_udf) begin
            t2_cnt_r <= t2_low_period_reload_r;
        end else if (t2_tick) begin
            t2_cnt_r <= t2_cnt_r - 8'h01;
        end
        if (!t2_ctrl_r[3]) begin
            t2_pwm_signal_r <= 1'b0;
        end
    end
end

// -----------------------------------------------------------------
// counter pin outputs
// -----------------------------------------------------------------
reg pwm_gate_r;

// pin 0 square wave, pin 1 gated pwm, enables from pin control
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        COUNTER_PIN_ZERO_OUT <= 1'b0;
        COUNTER_PIN_ZERO_OE_N <= 1'b1;
        COUNTER_PIN_ONE_OUT <= 1'b0;
        COUNTER_PIN_ONE_OE_N <= 1'b1;
        pwm_gate_r <= 1'b1;
        t2_pwm_hist_r <= 1'b0;
    end else if (CE) begin
        t2_pwm_hist_r <= t2_pwm_signal_r;
        if (t1_underflow_sig && t1_ctrl_r[3]) begin
            COUNTER_PIN_ZERO_OUT <= ~COUNTER_PIN_ZERO_OUT;
        end
        COUNTER_PIN_ZERO_OE_N <= ~pin0_counter_ctrl_r[3];
        if (!pin1_counter_ctrl_r[2]) begin
            pwm_gate_r <= 1'b1;
        end else if (t1_underflow_sig) begin
            pwm_gate_r <= ~pwm_gate_r;
        end
        COUNTER_PIN_ONE_OUT <= t2_pwm_signal_r & pwm_gate_r;
        COUNTER_PIN_ONE_OE_N <= ~pin1_counter_ctrl_r[3];
    end
end

// -----------------------------------------------------------------
// watchdog
// -----------------------------------------------------------------
reg [15:0] wdt_cnt_r;
wire wdt_restart = wr && PADDR == `A_WDT_CTRL && PWDATA[1];

// counts machine cycles, restart op clears, limit fires reset
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        wdt_cnt_r <= 16'h0000;
        WDT_RESET <= 1'b0;
    end else if (CE) begin
        WDT_RESET <= 1'b0;
        if (!wdt_en_r || wdt_restart) begin
            wdt_cnt_r <= 16'h0000;
        end else if (mc_tick) begin
            if (wdt_cnt_r == `WDT_LIMIT) begin
                wdt_cnt_r <= 16'h0000;
                WDT_RESET <= 1'b1;
            end else begin
                wdt_cnt_r <= wdt_cnt_r + 16'h0001;
            end
        end
    end
end

// -----------------------------------------------------------------
// control registers and interrupt status
// -----------------------------------------------------------------
wire [3:0] irq_set = {period_edge, t2_udf | (t2_tick & period_mode &
    (t2_cnt_r == 8'hff)), t1_underflow_sig, ext_edge};
wire [3:0] irq_clr = (wr && PADDR == `A_IRQ_STATUS) ? wd4 : 4'h0;

// software writes; status set wins over write-one-to-clear
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        prescaler_ctrl_r <= 1'b0;
        t1_ctrl_r <= `RST_CTRL4;
        t2_ctrl_r <= `RST_CTRL4;
        pin0_counter_ctrl_r <= `RST_CTRL4;
        pin1_counter_ctrl_r <= `RST_CTRL4;
        ext_pin_irq_ctrl_r <= `RST_CTRL4;
        prescaler_reload_value_r <= `RST_RELOAD8;
        t1_reload_value_r <= `RST_RELOAD8;
        t2_low_period_reload_r <= `RST_RELOAD8;
        t2_high_period_reload_r <= `RST_RELOAD8;
        irq_enable_ctrl_r <= 4'h0;
        irq_status_r <= 4'h0;
        wdt_en_r <= 1'b0;
        IRQ <= 1'b0;
    end else if (CE) begin
        if (wr) begin
            case (PADDR)
                `A_PRESCALER_CTRL: prescaler_ctrl_r <= PWDATA[0];
                `A_T1_CTRL: t1_ctrl_r <= wd4;
                `A_T2_CTRL: t2_ctrl_r <= wd4;
                `A_PIN0_CTRL: pin0_counter_ctrl_r <= wd4;
                `A_PIN1_CTRL: pin1_counter_ctrl_r <= wd4;
                `A_EXT_IRQ_CTRL: ext_pin_irq_ctrl_r <= wd4;
                `A_PRESC_RELOAD: prescaler_reload_value_r <= wd8;
                `A_T1_RELOAD: t1_reload_value_r <= wd8;
                `A_T2_LOW_RELOAD: t2_low_period_reload_r <= wd8;
                `A_T2_HIGH_RELOAD: t2_high_period_reload_r <= wd8;
                `A_IRQ_ENABLE: irq_enable_ctrl_r <= wd4;
                `A_WDT_CTRL: wdt_en_r <= wdt_en_r | PWDATA[0];
                default: ;
            endcase
        end
        irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
        IRQ <= |(irq_status_r & irq_enable_ctrl_r);
    end
end

// -----------------------------------------------------------------
// apb read and answer
// -----------------------------------------------------------------
reg [7:0] rdata;
reg mapped;

// read mux and address check
always @* begin
    mapped = 1'b1;
    case (PADDR)
        `A_PRESCALER_CTRL: rdata = {7'h00, prescaler_ctrl_r};
        `A_T1_CTRL: rdata = {4'h0, t1_ctrl_r};
        `A_T2_CTRL: rdata = {4'h0, t2_ctrl_r};
        `A_PIN0_CTRL: rdata = {4'h0, pin0_counter_ctrl_r};
        `A_PIN1_CTRL: rdata = {4'h0, pin1_counter_ctrl_r};
        `A_EXT_IRQ_CTRL: rdata = {4'h0, ext_pin_irq_ctrl_r};
        `A_PRESC_RELOAD: rdata = prescaler_reload_value_r;
        `A_T1_RELOAD: rdata = t1_reload_value_r;
        `A_T2_LOW_RELOAD: rdata = t2_low_period_reload_r;
        `A_T2_HIGH_RELOAD: rdata = t2_high_period_reload_r;
        `A_T1_COUNT: rdata = t1_cnt_r;
        `A_T2_COUNT: rdata = t2_cnt_r;
        `A_PERIOD_CAPTURE: rdata = period_cap_r;
        `A_IRQ_STATUS: rdata = {4'h0, irq_status_r};
        `A_IRQ_ENABLE: rdata = {4'h0, irq_enable_ctrl_r};
        `A_WDT_CTRL: rdata = {7'h00, wdt_en_r};
        default: begin
            rdata = 8'h00;
            mapped = 1'b0;
        end
    endcase
end

// one wait state: ready one cycle into the access phase
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        PREADY <= 1'b0;
        PRDATA <= 32'h00000000;
        PSLVERR <= 1'b0;
    end else if (CE) begin
        PREADY <= PSEL & PENABLE & ~PREADY;
        PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
        if (PSEL && PENABLE && !PREADY && !PWRITE) begin
            PRDATA <= {24'h000000, rdata};
        end
    end
end

endmodule // timer_subsys
`default_nettype wire

// *** tb/timer_subsys_monitor.sv ***
// apb answer and watchdog pulse checks for the timer subsystem
`timescale 1ns/1ns
`default_nettype none
module timer_subsys_monitor (
    input wire CLK_SYS,
    input wire RST,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire WDT_RESET
);
    // ------------------------------------------------------------
    // concurrent checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_ready_one_wait: assert property (PSEL && PENABLE && !$past(PENABLE)
        && CE && !PREADY |=> PREADY) else $error("pready late");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("pready held");
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("pready outside access");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("pslverr without pready");
    a_rdata_upper: assert property (PREADY && !PWRITE
        |-> PRDATA[31:8] == 24'h0) else $error("upper read bits set");
    a_unmapped_err: assert property (PREADY && PADDR > 8'h3c |-> PSLVERR)
        else $error("unmapped address accepted");
    a_mapped_ok: assert property (PREADY && PADDR <= 8'h3c
        && PADDR[1:0] == 2'b00 |-> !PSLVERR) else $error("mapped refused");
    a_wdt_pulse: assert property (WDT_RESET |=> !WDT_RESET [*8])
        else $error("watchdog reset not a single pulse");
endmodule // timer_subsys_monitor
bind timer_subsys timer_subsys_monitor u_mon (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .CE(CE),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .WDT_RESET(WDT_RESET)
);
`default_nettype wire

// *** tb/pulse_source.sv ***
// external pulse source on a counter pin
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] count,
    output logic busy,
    output logic pin
);
    // ------------------------------------------------------------
    // pulse train, two cycles high and two low
    // ------------------------------------------------------------
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                busy <= 1'b1;
                repeat (count) begin
                    pin <= 1'b1;
                    repeat (2) @(posedge clk);
                    pin <= 1'b0;
                    repeat (2) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule // pulse_source
`default_nettype wire

// *** tb/dual_timer_pwm_watchdog_tb.sv ***
// self-checking bench for the timer subsystem
`include "timer_subsys_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module dual_timer_pwm_watchdog_tb;
    logic clk_sys, rst, psel, penable, pwrite, go, busy, c0_in, int_in;
    logic [7:0] paddr, n_pulse;
    logic [31:0] pwdata, lfsr, prdata;
    logic pready, pslverr, c0_out, c0_oe_n, c1_out, c1_oe_n, irq, wdt;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int err_total, n_compared;
    timer_subsys dut (.CLK_SYS(clk_sys), .RST(rst), .CE(1'b1),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .COUNTER_PIN_ZERO_IN(c0_in),
        .COUNTER_PIN_ZERO_OUT(c0_out), .COUNTER_PIN_ZERO_OE_N(c0_oe_n),
        .COUNTER_PIN_ONE_IN(1'b0), .COUNTER_PIN_ONE_OUT(c1_out),
        .COUNTER_PIN_ONE_OE_N(c1_oe_n), .INT_IN(int_in), .RING_CLK_IN(1'b0),
        .IRQ(irq), .WDT_RESET(wdt));
    pulse_source u_src (.clk(clk_sys), .go(go), .count(n_pulse),
        .busy(busy), .pin(c0_in));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task end_sim;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    function logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] x, input logic xe);
        int k;
        exp_q.push_back({w, xe, x});
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            err_total++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, 1'b0);
    endtask
    task settle;
        repeat (3) @(posedge clk_sys);
    endtask
    task wait_change(input logic sel, input int bound, output int n);
        logic lvl;
        lvl = sel ? c1_out : c0_out;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((sel ? c1_out : c0_out) === lvl && n < bound);
        if ((sel ? c1_out : c0_out) === lvl)
            n = -1;
    endtask
    task pulses(input logic [7:0] cnt);
        int k;
        @(posedge clk_sys);
        n_pulse <= cnt;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (busy !== 1'b0 && k < 2000);
        if (busy !== 1'b0) begin
            err_total++;
            end_sim();
        end
    endtask
    // answer checker, oldest note against each apb answer
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            if (!e[33])
                chk("read data", e[31:0], prdata);
            chk("slave error", {31'h0, e[32]}, {31'h0, pslverr});
        end
    end
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        {psel, penable, pwrite, go, int_in, paddr, n_pulse, pwdata} = '0;
        err_total = 0;
        n_compared = 0;
        lfsr = 32'hf81dfaea;
        rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`A_T1_RELOAD, 32'hff);
        rd(`A_IRQ_STATUS, 32'h0);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h44, 32'h5, 32'h0, 1'b1);
        repeat (3) begin
            lfsr = lfsr_next(lfsr);
            wr(`A_T2_HIGH_RELOAD, {24'h0, lfsr[7:0]});
            rd(`A_T2_HIGH_RELOAD, {24'h0, lfsr[7:0]});
        end
        // square wave on pin 0 from timer 1
        wr(`A_PRESC_RELOAD, 32'h3);
        wr(`A_T1_RELOAD, 32'h29);
        wr(`A_PIN0_CTRL, 32'h8);
        wr(`A_T1_CTRL, 32'hd);
        wr(`A_PRESCALER_CTRL, 32'h1);
        wait_change(1'b0, 1200, n);
        wait_change(1'b0, 1200, n);
        chk("square half period", 504, n);
        chk("pin0 drive", 32'h0, {31'h0, c0_oe_n});
        rd(`A_IRQ_STATUS, 32'h2);
        wr(`A_PRESCALER_CTRL, 32'h0);
        wait_change(1'b0, 1200, n);
        chk("stopped prescaler", -1, n);
        wr(`A_PIN0_CTRL, 32'h1);
        wr(`A_T1_CTRL, 32'h0);
        settle();
        chk("pin0 released", 32'h1, {31'h0, c0_oe_n});
        // event count on pin 0 by timer 2
        wr(`A_IRQ_STATUS, 32'hf);
        wr(`A_T2_LOW_RELOAD, 32'h63);
        wr(`A_T2_CTRL, 32'h6);
        pulses(8'd99);
        rd(`A_IRQ_STATUS, 32'h0);
        pulses(8'd1);
        rd(`A_IRQ_STATUS, 32'h4);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`A_IRQ_ENABLE, 32'h4);
        settle();
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`A_IRQ_STATUS, 32'h4);
        settle();
        chk("irq cleared", 32'h0, {31'h0, irq});
        // pwm on pin 1 from timer 2 on the system clock
        wr(`A_T2_CTRL, 32'h0);
        wr(`A_T2_LOW_RELOAD, 32'h3);
        wr(`A_T2_HIGH_RELOAD, 32'h2);
        wr(`A_PIN1_CTRL, 32'h8);
        wr(`A_T2_CTRL, 32'hf);
        wait_change(1'b1, 50, n);
        if (c1_out !== 1'b1)
            wait_change(1'b1, 50, n);
        wait_change(1'b1, 50, n);
        chk("pwm high time", 3, n);
        wait_change(1'b1, 50, n);
        chk("pwm low time", 4, n);
        chk("pin1 drive", 32'h0, {31'h0, c1_oe_n});
        // timer 1 started by a rising external pin edge, then auto-stop
        wr(`A_T2_CTRL, 32'h0);
        wr(`A_PRESC_RELOAD, 32'h0);
        wr(`A_T1_RELOAD, 32'h52);
        wr(`A_IRQ_ENABLE, 32'h2);
        wr(`A_EXT_IRQ_CTRL, 32'hc);
        wr(`A_EXT_IRQ_CTRL, 32'hd);
        wr(`A_IRQ_STATUS, 32'hf);
        wr(`A_PIN0_CTRL, 32'h7);
        wr(`A_T1_CTRL, 32'h5);
        wr(`A_PRESCALER_CTRL, 32'h1);
        settle();
        rd(`A_T1_COUNT, 32'h52);
        int_in <= 1'b1;
        repeat (230) @(posedge clk_sys);
        rd(`A_IRQ_STATUS, 32'h1);
        repeat (30) @(posedge clk_sys);
        rd(`A_IRQ_STATUS, 32'h3);
        rd(`A_T1_COUNT, 32'h52);
        chk("timer1 irq", 32'h1, {31'h0, irq});
        // period of the external pin counted by timer 2
        int_in <= 1'b0;
        wr(`A_PIN1_CTRL, 32'h2);
        wr(`A_T2_CTRL, 32'h7);
        int_in <= 1'b1;
        repeat (50) @(posedge clk_sys);
        int_in <= 1'b0;
        repeat (50) @(posedge clk_sys);
        int_in <= 1'b1;
        settle();
        settle();
        rd(`A_PERIOD_CAPTURE, 32'h64);
        end_sim();
    end
endmodule // dual_timer_pwm_watchdog_tb
`default_nettype wire
